// ==== ext_meter_model.sv ====
// External meter and trigger source model
`timescale 1ns/100ps
module ext_meter_model (
   input  wire logic       clk_in, cn_in, go_in, fall_in,
   input  wire logic [7:0] wid_in,
   output logic            trig_out
);
   logic last_r = 1'b1;
   int   left = 0;
   assign trig_out = fall_in ^ (left > 0);
   always @(posedge clk_in) begin
      #2;
      if (go_in || (last_r && !cn_in)) left = wid_in;
      else if (left > 0) left--;
      last_r = cn_in;
   end
endmodule

// ==== scan_trigger_alarm_io.sv ====
// Rear-panel alarm, channel-closed and trigger pin logic
// Functional notes
// - Four alarm outputs pulse on alarm
// - About 7 us low pulse per measurement
// - Closed pulses at most 1000 per second
// - Trigger pulses of 2 us or more accepted
// - Trigger edge rising or falling, selectable
// - Closed output and trigger pace external meter
`timescale 1ns/100ps
`include "trig_alarm_map.svh"
module scan_trigger_alarm_io
   import trig_alarm_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       arst_n_in,
   input  wire logic [3:0] alarm_raise_in,
   input  wire logic       meas_done_in,
   input  wire logic       trig_in,
   input  wire logic       ext_trig_mode_in,
   input  wire logic       edge_falling_in,
   output logic            alarm_out_first,
   output logic            alarm_out_second,
   output logic            alarm_out_third,
   output logic            alarm_out_fourth,
   output logic            channel_closed_pulse_n_out,
   output logic            trigger_event_out
);
   import trig_alarm_pkg::*;

   logic [3:0]    alarm_r, alarm_nxt;
   count_t        alarm_cnt_r [4];
   count_t        alarm_cnt_nxt [4];
   closed_state_t cl_state_r, cl_state_nxt;
   count_t        cl_cnt_r, cl_cnt_nxt;
   logic          cl_pend_r, cl_pend_nxt;
   logic          closed_n_r, closed_n_nxt;

   // Trigger acts as the channel-advance input in external mode
   trig_edge_filter u_trig (
      .mclk_in         (mclk_in),
      .arst_n_in       (arst_n_in),
      .trig_in         (trig_in),
      .edge_falling_in (edge_falling_in),
      .enable_in       (ext_trig_mode_in),
      .trig_event_out  (trigger_event_out)
   );

   // Alarm pulses retrigger on a new raise, so none is lost
   always_comb begin
      for (int i = 0; i < `NUM_ALARMS; i++) begin
         alarm_cnt_nxt[i] = alarm_cnt_r[i];
         alarm_nxt[i]     = alarm_r[i];
         if (alarm_raise_in[i]) begin
            alarm_cnt_nxt[i] = 16'(`ALARM_PULSE_CYC - 1);
            alarm_nxt[i]     = 1'b1;
         end else if (alarm_cnt_r[i] != 16'h0000) begin
            alarm_cnt_nxt[i] = alarm_cnt_r[i] - 16'h0001;
         end else begin
            alarm_nxt[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         alarm_r <= 4'h0;
         for (int i = 0; i < `NUM_ALARMS; i++) begin
            alarm_cnt_r[i] <= 16'h0000;
         end
      end else begin
         alarm_r     <= alarm_nxt;
         alarm_cnt_r <= alarm_cnt_nxt;
      end
   end

   assign alarm_out_first  = alarm_r[0];
   assign alarm_out_second = alarm_r[1];
   assign alarm_out_third  = alarm_r[2];
   assign alarm_out_fourth = alarm_r[3];

   // A completion during pulse or gap is held pending, then served
   always_comb begin
      cl_state_nxt = cl_state_r;
      cl_cnt_nxt   = cl_cnt_r;
      cl_pend_nxt  = cl_pend_r | meas_done_in;
      closed_n_nxt = closed_n_r;
      case (cl_state_r)
         CL_IDLE: begin
            closed_n_nxt = 1'b1;
            if (cl_pend_r || meas_done_in) begin
               cl_pend_nxt  = 1'b0;
               closed_n_nxt = 1'b0;
               cl_cnt_nxt   = 16'(`CLOSED_PULSE_CYC - 1);
               cl_state_nxt = CL_PULSE;
            end
         end
         CL_PULSE: begin
            if (cl_cnt_r != 16'h0000) begin
               cl_cnt_nxt = cl_cnt_r - 16'h0001;
            end else begin
               closed_n_nxt = 1'b1;
               // Spacing from start to start is one millisecond
               cl_cnt_nxt   = 16'(`MIN_RATE_PERIOD_CYC
                                  - `CLOSED_PULSE_CYC - 2);
               cl_state_nxt = CL_GAP;
            end
         end
         CL_GAP: begin
            if (cl_cnt_r != 16'h0000) begin
               cl_cnt_nxt = cl_cnt_r - 16'h0001;
            end else begin
               cl_state_nxt = CL_IDLE;
            end
         end
         default: begin
            cl_state_nxt = CL_IDLE;
            closed_n_nxt = 1'b1;
         end
      endcase
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cl_state_r <= CL_IDLE;
         cl_cnt_r   <= 16'h0000;
         cl_pend_r  <= 1'b0;
         closed_n_r <= 1'b1;
      end else begin
         cl_state_r <= cl_state_nxt;
         cl_cnt_r   <= cl_cnt_nxt;
         cl_pend_r  <= cl_pend_nxt;
         closed_n_r <= closed_n_nxt;
      end
   end

   assign channel_closed_pulse_n_out = closed_n_r;
endmodule

// ==== sta_properties.sv ====
// Checker for the trigger and alarm pin logic
`timescale 1ns/100ps
module sta_chk (
   input wire logic       mclk_in, arst_n_in, ext_trig_mode_in,
   input wire logic       edge_falling_in, trig_in, alarm_out_first,
   input wire logic       channel_closed_pulse_n_out, trigger_event_out,
   input wire logic [3:0] alarm_raise_in
);
   wire         cn = channel_closed_pulse_n_out, ev = trigger_event_out;
   wire         a0 = alarm_out_first, r0 = alarm_raise_in[0];
   logic [15:0] gap_r;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   always_ff @(posedge mclk_in or negedge arst_n_in)
      if (!arst_n_in) gap_r <= 16'hffff;
      else if ($fell(cn)) gap_r <= 16'h0001;
      else if (gap_r != 16'hffff) gap_r <= gap_r + 16'h0001;
   a_alarm_start: assert property (r0 |=> a0) else $error("alarm");
   a_alarm_end: assert property ($fell(a0) |-> $past(r0, 281))
      else $error("alarm width");
   a_closed_width: assert property ($fell(cn) |-> ##279 !cn ##1 cn)
      else $error("closed width");
   a_closed_rate: assert property ($fell(cn) |-> gap_r >= 16'h9c40)
      else $error("closed rate");
   a_trig_once: assert property (ev |=> !ev) else $error("twice");
   a_trig_mode: assert property (!ext_trig_mode_in [*3] |-> !ev)
      else $error("mode off");
   a_trig_width: assert property
      (ev |-> $past(trig_in ^ edge_falling_in, 5) &&
       $past(trig_in ^ edge_falling_in, 60)) else $error("short");
   c_alarm: cover property ($fell(a0));
   c_closed: cover property ($rose(cn));
   c_trig: cover property (ev && edge_falling_in);
endmodule
bind scan_trigger_alarm_io sta_chk chk_u (.*);

// ==== tb.sv ====
// Bench for the trigger and alarm pin logic
`timescale 1ns/100ps
module tb;
   logic       clk = 1'b0, rst_n = 1'b0, done = 1'b0, go = 1'b0;
   logic       mode = 1'b1, fall = 1'b0, cn, ev, trig;
   logic [3:0] raise = 4'h0, al;
   logic [7:0] wid = 8'h5a;
   int         fails = 0, checks = 0, cyc = 0, n = 0, t0;
   scan_trigger_alarm_io dut_u (.mclk_in(clk), .arst_n_in(rst_n),
      .alarm_raise_in(raise), .meas_done_in(done), .trig_in(trig),
      .ext_trig_mode_in(mode), .edge_falling_in(fall),
      .alarm_out_first(al[0]), .alarm_out_second(al[1]),
      .alarm_out_third(al[2]), .alarm_out_fourth(al[3]),
      .channel_closed_pulse_n_out(cn), .trigger_event_out(ev));
   ext_meter_model mdl_u (.clk_in(clk), .cn_in(cn), .go_in(go),
      .fall_in(fall), .wid_in(wid), .trig_out(trig));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      n += ev;
   end
   task automatic chk(input logic [15:0] g, e);
      checks++;
      if (g !== e) fails++;
      if (g !== e) $display("ERROR %0t %h %h", $time, g, e);
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic kick(input logic d);
      done = d;
      go = !d;
      step(1);
      done = 1'b0;
      go = 1'b0;
      n = 0;
   endtask
   task automatic end_of_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic alarm_case;
      for (int i = 0; i < 4; i++) begin
         raise[i] = 1'b1;
         step(1);
         raise = 4'h0;
         chk(al, 4'h1 << i);
         step(280);
         chk(al, 4'h0);
      end
   endtask
   task automatic closed_case;
      kick(1'b1);
      chk(cn, 1'b0);
      t0 = cyc;
      step(600);
      chk(16'(n), 16'h0001);
      kick(1'b1);
      for (int k = 0; k < 41000 && cn === 1'b1; k++) step(1);
      chk(16'(cyc - t0), 16'h9c40);
      if (cn !== 1'b0) end_of_test();
   endtask
   task automatic trig_case(input logic f, m, input logic [7:0] w,
                            input logic [15:0] e);
      fall = f;
      mode = m;
      wid = w;
      step(4100);
      kick(1'b0);
      step(300);
      chk(16'(n), e);
   endtask
   initial begin
      step(16);
      rst_n = 1'b1;
      step(1);
      alarm_case();
      closed_case();
      trig_case(1'b0, 1'b1, 8'h5a, 16'h0001);
      trig_case(1'b0, 1'b1, 8'h28, 16'h0000);
      trig_case(1'b1, 1'b1, 8'h5a, 16'h0001);
      trig_case(1'b1, 1'b0, 8'h5a, 16'h0000);
      end_of_test();
   end
endmodule

// ==== trig_alarm_map.svh ====
// Constants for the trigger and alarm pin logic
`ifndef TRIG_ALARM_MAP_SVH
`define TRIG_ALARM_MAP_SVH
`define CLK_PERIOD_NS        25
`define CLOSED_PULSE_NS      7000
`define CLOSED_PULSE_CYC     ((`CLOSED_PULSE_NS) / (`CLK_PERIOD_NS))
`define MIN_RATE_PERIOD_NS   1000000
`define MIN_RATE_PERIOD_CYC  ((`MIN_RATE_PERIOD_NS) / (`CLK_PERIOD_NS))
`define TRIG_MIN_WIDTH_NS    2000
`define TRIG_MIN_WIDTH_CYC   (((`TRIG_MIN_WIDTH_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define ALARM_PULSE_NS       7000
`define ALARM_PULSE_CYC      ((`ALARM_PULSE_NS) / (`CLK_PERIOD_NS))
`define NUM_ALARMS           4
`define CNT_W                16
`endif

// ==== trig_alarm_pkg.sv ====
// Types shared by the trigger and alarm pin logic
package trig_alarm_pkg;
   typedef logic [15:0] count_t;
   typedef enum logic [1:0] {
      CL_IDLE  = 2'b00,
      CL_PULSE = 2'b01,
      CL_GAP   = 2'b10
   } closed_state_t;
endpackage

// ==== trig_edge_filter.sv ====
// Trigger input synchroniser, edge select and width qualifier
`timescale 1ns/100ps
`include "trig_alarm_map.svh"
module trig_edge_filter
   import trig_alarm_pkg::*;
(
   input  wire logic mclk_in,
   input  wire logic arst_n_in,
   input  wire logic trig_in,
   input  wire logic edge_falling_in,
   input  wire logic enable_in,
   output logic      trig_event_out
);
   logic   sync1_r, sync2_r, sync1_nxt, sync2_nxt;
   logic   armed_r, armed_nxt;
   logic   ev_r, ev_nxt;
   count_t width_r, width_nxt;
   logic   active;

   always_comb begin
      sync1_nxt = trig_in;
      sync2_nxt = sync1_r;
      // Active level follows the selected edge
      active    = edge_falling_in ? ~sync2_r : sync2_r;
      width_nxt = width_r;
      armed_nxt = armed_r;
      ev_nxt    = 1'b0;
      if (!active || !enable_in) begin
         width_nxt = '0;
         armed_nxt = 1'b1;
      end else if (armed_r) begin
         if (width_r == 16'(`TRIG_MIN_WIDTH_CYC - 1)) begin
            ev_nxt    = 1'b1;
            armed_nxt = 1'b0;
         end else begin
            width_nxt = width_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         width_r <= 16'h0000;
         armed_r <= 1'b0;
         ev_r    <= 1'b0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         width_r <= width_nxt;
         armed_r <= armed_nxt;
         ev_r    <= ev_nxt;
      end
   end

   assign trig_event_out = ev_r;
endmodule
